/* uie_gate.sv */
// Interrupt enable gating of the USB controller, reached over classic Wishbone.
// Assumes event pulses one cycle long from the serial engine on clk_i.
`timescale 1ns/1ps
module uie_gate
    import uie_pkg::*;
(
    input  wire logic           clk_i,
    input  wire logic           rst_i,
    input  wire uie_wb_req_type wb_req_i,
    output uie_wb_rsp_type      wb_rsp_o,
    input  wire uie_event_type  sie_event_i,
    output logic                usb_combined_irq_o
);

    uie_state_type         state_ff;
    uie_state_type         nxt_state;

    logic                  access;
    logic                  wr_lane0;
    logic                  rd_req;
    logic [UIE_SRC_W-1:0]  flags;
    logic [UIE_ERR_W-1:0]  err_flags;
    logic [UIE_SRC_W-1:0]  flag_set;
    logic [UIE_SRC_W-1:0]  flag_clr;
    logic [UIE_ERR_W-1:0]  err_clr;
    logic [UIE_SRC_W-1:0]  gated;

    // =========================================================
    // Bus decode
    assign access   = wb_req_i.cyc & wb_req_i.stb & ~state_ff.ack;
    assign wr_lane0 = access & wb_req_i.we & wb_req_i.sel[0];
    assign rd_req   = access & ~wb_req_i.we;

    // =========================================================
    // Event to flag mapping
    always_comb begin
        flag_set              = '0;
        flag_set[BIT_STALL]   = sie_event_i.stall;
        flag_set[BIT_ATTACH]  = sie_event_i.attach;
        flag_set[BIT_RESUME]  = sie_event_i.resume;
        flag_set[BIT_IDLE]    = sie_event_i.bus_idle;
        flag_set[BIT_TOKEN]   = sie_event_i.token_done;
        flag_set[BIT_SOF]     = sie_event_i.frame_start;
        // Summary error from enabled individual errors
        flag_set[BIT_UERR]    = |(sie_event_i.errors & state_ff.err_en);
        // Bit 0 source follows the operating mode
        if (state_ff.host_mode) begin
            flag_set[BIT_RST_DET] = sie_event_i.detach;
        end else begin
            flag_set[BIT_RST_DET] = sie_event_i.bus_reset;
        end
    end

    // =========================================================
    // Write-one-to-clear
    always_comb begin
        flag_clr = '0;
        err_clr  = '0;
        if (wr_lane0 && wb_req_i.adr == OFS_FLAGS) begin
            flag_clr = wb_req_i.dat[UIE_SRC_W-1:0];
        end
        if (wr_lane0 && wb_req_i.adr == OFS_ERR_FLAGS) begin
            err_clr = wb_req_i.dat[UIE_ERR_W-1:0];
        end
    end

    uie_sticky #(
        .WIDTH (UIE_SRC_W)
    ) u_flags (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .set_i   (flag_set),
        .clr_i   (flag_clr),
        .flags_o (flags)
    );

    uie_sticky #(
        .WIDTH (UIE_ERR_W)
    ) u_err_flags (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .set_i   (sie_event_i.errors),
        .clr_i   (err_clr),
        .flags_o (err_flags)
    );

    // =========================================================
    // Gating, one enable per flag
    assign gated = flags & state_ff.enable;

    // =========================================================
    // Next state
    always_comb begin
        nxt_state       = state_ff;
        nxt_state.ack   = access;
        nxt_state.rdata = RST_RDATA;
        nxt_state.irq   = |gated;
        if (rd_req) begin
            case (wb_req_i.adr)
                OFS_ENABLE: begin
                    nxt_state.rdata[UIE_SRC_W-1:0] = state_ff.enable;
                end
                OFS_FLAGS: begin
                    nxt_state.rdata[UIE_SRC_W-1:0] = flags;
                end
                OFS_ERR_FLAGS: begin
                    nxt_state.rdata[UIE_ERR_W-1:0] = err_flags;
                end
                OFS_ERR_EN: begin
                    nxt_state.rdata[UIE_ERR_W-1:0] = state_ff.err_en;
                end
                OFS_CTRL: begin
                    nxt_state.rdata[BIT_HOST] = state_ff.host_mode;
                end
                default: begin
                    nxt_state.rdata = RST_RDATA;
                end
            endcase
        end
        if (wr_lane0) begin
            case (wb_req_i.adr)
                OFS_ENABLE: begin
                    // Upper bits dropped
                    nxt_state.enable = wb_req_i.dat[UIE_SRC_W-1:0];
                end
                OFS_ERR_EN: begin
                    nxt_state.err_en = wb_req_i.dat[UIE_ERR_W-1:0];
                end
                OFS_CTRL: begin
                    nxt_state.host_mode = wb_req_i.dat[BIT_HOST];
                end
                default: begin
                    nxt_state.host_mode = state_ff.host_mode;
                end
            endcase
        end
    end

    // =========================================================
    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff.enable    <= RST_ENABLE;
            state_ff.err_en    <= RST_ERR_EN;
            state_ff.host_mode <= RST_HOST;
            state_ff.ack       <= 1'b0;
            state_ff.rdata     <= RST_RDATA;
            state_ff.irq       <= 1'b0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign wb_rsp_o.ack       = state_ff.ack;
    assign wb_rsp_o.dat       = state_ff.rdata;
    assign usb_combined_irq_o = state_ff.irq;

    // =========================================================
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence enable_read_s;
        rd_req && wb_req_i.adr == OFS_ENABLE;
    endsequence

    sequence enable_write_s;
        wr_lane0 && wb_req_i.adr == OFS_ENABLE;
    endsequence

    sequence token_event_s;
        sie_event_i.token_done && state_ff.enable[BIT_TOKEN] && !(wr_lane0 && wb_req_i.adr == OFS_ENABLE);
    endsequence

    upper_zero_a: assert property (
        enable_read_s |=> wb_rsp_o.ack && wb_rsp_o.dat[31:8] == 24'h00_0000
            && wb_rsp_o.dat[7:0] == $past(state_ff.enable))
        else $error("enable read shows wrong bits");

    stall_gate_a: assert property (
        flags[BIT_STALL] && state_ff.enable[BIT_STALL] |=> usb_combined_irq_o)
        else $error("enabled stall flag did not interrupt");

    attach_block_a: assert property (
        flags == 8'h40 && !state_ff.enable[BIT_ATTACH] |=> !usb_combined_irq_o)
        else $error("disabled attach flag interrupted");

    resume_gate_a: assert property (
        flags[BIT_RESUME] && state_ff.enable[BIT_RESUME] |=> usb_combined_irq_o)
        else $error("enabled resume flag did not interrupt");

    idle_block_a: assert property (
        flags == 8'h10 && !state_ff.enable[BIT_IDLE] |=> !usb_combined_irq_o)
        else $error("disabled idle flag interrupted");

    token_path_a: assert property (
        token_event_s |=> flags[BIT_TOKEN] ##1 usb_combined_irq_o)
        else $error("token done did not reach interrupt in two cycles");

    sof_block_a: assert property (
        flags == 8'h04 && !state_ff.enable[BIT_SOF] |=> !usb_combined_irq_o)
        else $error("disabled frame start flag interrupted");

    error_set_a: assert property (
        |(sie_event_i.errors & state_ff.err_en) |=> flags[BIT_UERR] && err_flags != 8'h00)
        else $error("enabled error did not set summary flag");

    error_gate_a: assert property (
        flags == 8'h02 && !state_ff.enable[BIT_UERR] |=> !usb_combined_irq_o)
        else $error("error reached interrupt with bit 1 clear");

    device_reset_a: assert property (
        !state_ff.host_mode && sie_event_i.bus_reset |=> flags[BIT_RST_DET])
        else $error("bus reset flag not set in device mode");

    host_detach_a: assert property (
        state_ff.host_mode && !sie_event_i.detach && !flags[BIT_RST_DET]
            && !flag_clr[BIT_RST_DET] |=> !flags[BIT_RST_DET])
        else $error("bit 0 set in host mode without detach");

    enable_write_a: assert property (
        enable_write_s |=> state_ff.enable == $past(wb_req_i.dat[7:0]))
        else $error("enable write not stored");

    enable_reset_a: assert property (@(posedge clk_i) disable iff (1'b0)
        rst_i |=> state_ff.enable == RST_ENABLE && !usb_combined_irq_o)
        else $error("enable not cleared by reset");

    irq_follow_a: assert property (
        1 |=> usb_combined_irq_o == $past(|(flags & state_ff.enable)))
        else $error("interrupt does not follow enabled flags");

    ack_pulse_a: assert property (
        access |=> wb_rsp_o.ack ##1 !wb_rsp_o.ack)
        else $error("ack not a single cycle");

    dat_idle_a: assert property (
        !wb_rsp_o.ack |-> wb_rsp_o.dat == RST_RDATA)
        else $error("read data not zero outside ack");

    sel_ignore_a: assert property (
        access && wb_req_i.we && !wb_req_i.sel[0] |=> state_ff.enable == $past(state_ff.enable))
        else $error("enable written with lane zero off");

    // =========================================================
    // Checks, per-source gating
    attach_gate_a: assert property (
        flags[BIT_ATTACH] && state_ff.enable[BIT_ATTACH] |=> usb_combined_irq_o)
        else $error("enabled attach flag did not interrupt");

    idle_gate_a: assert property (
        flags[BIT_IDLE] && state_ff.enable[BIT_IDLE] |=> usb_combined_irq_o)
        else $error("enabled idle flag did not interrupt");

    sof_gate_a: assert property (
        flags[BIT_SOF] && state_ff.enable[BIT_SOF] |=> usb_combined_irq_o)
        else $error("enabled frame start flag did not interrupt");

    error_irq_a: assert property (
        flags[BIT_UERR] && state_ff.enable[BIT_UERR] |=> usb_combined_irq_o)
        else $error("enabled error flag did not interrupt");

    bit0_gate_a: assert property (
        flags[BIT_RST_DET] && state_ff.enable[BIT_RST_DET] |=> usb_combined_irq_o)
        else $error("enabled bit 0 flag did not interrupt");

    stall_block_a: assert property (
        flags == 8'h80 && !state_ff.enable[BIT_STALL] |=> !usb_combined_irq_o)
        else $error("disabled stall flag interrupted");

    resume_block_a: assert property (
        flags == 8'h20 && !state_ff.enable[BIT_RESUME] |=> !usb_combined_irq_o)
        else $error("disabled resume flag interrupted");

    token_block_a: assert property (
        flags == 8'h08 && !state_ff.enable[BIT_TOKEN] |=> !usb_combined_irq_o)
        else $error("disabled token done flag interrupted");

    bit0_block_a: assert property (
        flags == 8'h01 && !state_ff.enable[BIT_RST_DET] |=> !usb_combined_irq_o)
        else $error("disabled bit 0 flag interrupted");

    // =========================================================
    // Checks, flag sources
    err_flag_set_a: assert property (
        sie_event_i.errors != 8'h00
            |=> (err_flags & $past(sie_event_i.errors)) == $past(sie_event_i.errors))
        else $error("error pulse not held in error flags");

    flags_hold_a: assert property (
        !(|flag_set) && !(|flag_clr) |=> flags == $past(flags))
        else $error("flags changed without event or clear");

    error_block_a: assert property (
        !(|(sie_event_i.errors & state_ff.err_en)) && !flags[BIT_UERR]
            |=> !flags[BIT_UERR])
        else $error("summary error set without enabled error");

    device_detach_a: assert property (
        !state_ff.host_mode && !sie_event_i.bus_reset && !flags[BIT_RST_DET]
            |=> !flags[BIT_RST_DET])
        else $error("bit 0 set in device mode without bus reset");

    host_set_a: assert property (
        state_ff.host_mode && sie_event_i.detach |=> flags[BIT_RST_DET])
        else $error("detach flag not set in host mode");

endmodule // uie_gate

/* uie_pkg.sv */
// Package with constants and carrier types for the USB interrupt enable gating block.
// Assumes a classic Wishbone master, one 125 MHz clock and event pulses from the serial engine.
//
// Function
// - Only low eight enable bits exist; upper read zero
// - Bit 7 gates stall flag onto interrupt
// - Bit 6 gates attach flag onto interrupt
// - Bit 5 gates resume flag onto interrupt
// - Bit 4 gates bus idle flag onto interrupt
// - Bit 3 gates token done flag onto interrupt
// - Bit 2 gates frame start flag onto interrupt
// - Bit 1 gates summary error flag onto interrupt
// - Device mode: bit 0 gates bus reset flag
// - Host mode: bit 0 gates detach flag
// - Errors reach interrupt only while bit 1 set
// - Serial engine events feed the status flags
package uie_pkg;

    // =========================================================
    // Bus geometry
    localparam int unsigned UIE_ADR_W  = 8;
    localparam int unsigned UIE_DAT_W  = 32;
    localparam int unsigned UIE_SEL_W  = 4;
    localparam int unsigned UIE_SRC_W  = 8;
    localparam int unsigned UIE_ERR_W  = 8;

    // =========================================================
    // Register offsets
    localparam logic [7:0] OFS_ENABLE    = 8'h00;
    localparam logic [7:0] OFS_FLAGS     = 8'h04;
    localparam logic [7:0] OFS_ERR_FLAGS = 8'h08;
    localparam logic [7:0] OFS_ERR_EN    = 8'h0c;
    localparam logic [7:0] OFS_CTRL      = 8'h10;

    // =========================================================
    // Field positions
    localparam int unsigned BIT_STALL    = 7;
    localparam int unsigned BIT_ATTACH   = 6;
    localparam int unsigned BIT_RESUME   = 5;
    localparam int unsigned BIT_IDLE     = 4;
    localparam int unsigned BIT_TOKEN    = 3;
    localparam int unsigned BIT_SOF      = 2;
    localparam int unsigned BIT_UERR     = 1;
    localparam int unsigned BIT_RST_DET  = 0;
    localparam int unsigned BIT_HOST     = 0;

    // =========================================================
    // Reset values
    localparam logic [7:0] RST_ENABLE    = 8'h00;
    localparam logic [7:0] RST_FLAGS     = 8'h00;
    localparam logic [7:0] RST_ERR_EN    = 8'h00;
    localparam logic       RST_HOST      = 1'b0;
    localparam logic [31:0] RST_RDATA    = 32'h0000_0000;

    // =========================================================
    // Carrier types
    typedef struct packed {
        logic                 cyc;
        logic                 stb;
        logic                 we;
        logic [UIE_ADR_W-1:0] adr;
        logic [UIE_SEL_W-1:0] sel;
        logic [UIE_DAT_W-1:0] dat;
    } uie_wb_req_type;

    typedef struct packed {
        logic                 ack;
        logic [UIE_DAT_W-1:0] dat;
    } uie_wb_rsp_type;

    typedef struct packed {
        logic                 stall;
        logic                 attach;
        logic                 resume;
        logic                 bus_idle;
        logic                 token_done;
        logic                 frame_start;
        logic                 bus_reset;
        logic                 detach;
        logic [UIE_ERR_W-1:0] errors;
    } uie_event_type;

    typedef struct packed {
        logic [UIE_SRC_W-1:0] enable;
        logic [UIE_ERR_W-1:0] err_en;
        logic                 host_mode;
        logic                 ack;
        logic [UIE_DAT_W-1:0] rdata;
        logic                 irq;
    } uie_state_type;

endpackage

/* uie_sticky.sv */
// Bank of sticky flags: set by pulses, cleared by writing ones.
// Assumes set and clear come from logic on the same clock.
`timescale 1ns/1ps
module uie_sticky
    import uie_pkg::*;
#(
    parameter int unsigned WIDTH = 8
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] set_i,
    input  wire logic [WIDTH-1:0] clr_i,
    output logic      [WIDTH-1:0] flags_o
);

    typedef struct packed {
        logic [WIDTH-1:0] flags;
    } uie_sticky_state_type;

    uie_sticky_state_type state_ff;
    uie_sticky_state_type nxt_state;

    // =========================================================
    // Parameter check
    if (WIDTH < 1 || WIDTH > UIE_DAT_W) begin : g_bad_width
        $error("uie_sticky: WIDTH out of range");
    end

    // =========================================================
    // Next state, set wins over clear
    always_comb begin
        nxt_state       = state_ff;
        nxt_state.flags = (state_ff.flags & ~clr_i) | set_i;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff.flags <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign flags_o = state_ff.flags;

    // =========================================================
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    set_wins_a: assert property (1 |=> (flags_o & $past(set_i)) == $past(set_i))
        else $error("sticky flag lost a set");
    clr_works_a: assert property (1 |=> (flags_o & $past(clr_i & ~set_i)) == '0)
        else $error("sticky flag not cleared");

endmodule // uie_sticky

/* uie_sie_model.sv */
// Far-side model: the serial engine that raises one-cycle event pulses.
// Assumes bench commands arrive on the same clock as the gating block.
`timescale 1ns/1ps
module uie_sie_model
    import uie_pkg::*;
(
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    input  wire logic          go_i,
    input  wire uie_event_type cmd_i,
    output uie_event_type      sie_event_o
);
    // =========================================================
    // Event pulse, one cycle per command
    always_ff @(posedge clk_i) begin
        if (rst_i || !go_i) begin
            sie_event_o <= '0;
        end else begin
            sie_event_o <= cmd_i;
        end
    end
endmodule // uie_sie_model

/* tb.sv */
// Testbench for the interrupt enable gating block.
// Assumes classic Wishbone single cycles and one 125 MHz clock.
`timescale 1ns/1ps
module tb
    import uie_pkg::*;
    ;
    // =========================================================
    // Signals
    logic           clk_i     = 1'h0;
    logic           rst_i     = 1'h1;
    logic           go        = 1'h0;
    uie_wb_req_type req       = '0;
    uie_event_type  ev_cmd    = '0;
    uie_wb_rsp_type rsp;
    uie_event_type  sie_ev;
    logic           irq;
    logic [31:0]    rdat;
    int             bad_count = 0;
    int             n_tests   = 0;

    always #4 clk_i = ~clk_i;

    uie_gate dut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp),
                  .sie_event_i(sie_ev), .usb_combined_irq_o(irq));
    uie_sie_model far (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .cmd_i(ev_cmd), .sie_event_o(sie_ev));

    // =========================================================
    // Report and compare
    task automatic close_out();
        if (bad_count == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // =========================================================
    // Bus cycles
    task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd, input logic [3:0] sl);
        int n;
        n = 0;
        req <= '{cyc: 1'h1, stb: 1'h1, we: we, adr: adr, sel: sl, dat: wd};
        do begin
            @(posedge clk_i);
            n++;
        end while (rsp.ack !== 1'h1 && n < 20);
        rdat = rsp.dat;
        req  <= '0;
        if (rsp.ack !== 1'h1) begin
            bad_count++;
            $display("mismatch at %0t got %h exp %h", $time, rsp.ack, 1'h1);
            close_out();
        end else begin
            @(posedge clk_i);
        end
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] wd);
        xfer(1'h1, adr, wd, 4'hf);
    endtask

    task automatic rdc(input logic [7:0] adr, input logic [31:0] exp);
        xfer(1'h0, adr, 32'h0, 4'hf);
        chk32(rdat, exp);
    endtask

    // =========================================================
    // Events
    function automatic uie_event_type ev_of(input int k);
        uie_event_type e;
        e = '0;
        case (k)
            7: e.stall = 1'h1;
            6: e.attach = 1'h1;
            5: e.resume = 1'h1;
            4: e.bus_idle = 1'h1;
            3: e.token_done = 1'h1;
            2: e.frame_start = 1'h1;
            1: e.errors = 8'h01;
            0: e.bus_reset = 1'h1;
            default: e.detach = 1'h1;
        endcase
        return e;
    endfunction

    task automatic fire(input uie_event_type e);
        ev_cmd <= e;
        go     <= 1'h1;
        @(posedge clk_i);
        go <= 1'h0;
        repeat (3) @(posedge clk_i);
    endtask

    // One source: enable only its bit, or all bits but its own
    task automatic src(input int k, input int b, input logic en, input logic fl);
        logic [31:0] bit_v;
        bit_v = 32'h1 << b;
        wr(OFS_ENABLE, en ? bit_v : (32'hff ^ bit_v));
        fire(ev_of(k));
        rdc(OFS_FLAGS, fl ? bit_v : 32'h0);
        chk1(irq, en & fl);
        if (!en) begin
            wr(OFS_ENABLE, bit_v);
            @(posedge clk_i);
            chk1(irq, fl);
        end
        wr(OFS_FLAGS, 32'hff);
        wr(OFS_ERR_FLAGS, 32'hff);
        repeat (2) @(posedge clk_i);
        chk1(irq, 1'h0);
    endtask

    // =========================================================
    // Main sequence
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'h0;
        @(posedge clk_i);
        chk1(irq, 1'h0);
        rdc(OFS_ENABLE, 32'h0);
        wr(OFS_ENABLE, 32'hffff_ffff);
        rdc(OFS_ENABLE, 32'h0000_00ff);
        wr(OFS_ENABLE, 32'h0000_005a);
        rdc(OFS_ENABLE, 32'h0000_005a);
        xfer(1'h1, OFS_ENABLE, 32'h0000_00ff, 4'he);
        rdc(OFS_ENABLE, 32'h0000_005a);
        wr(8'h40, 32'hffff_ffff);
        rdc(8'h40, 32'h0);
        rdc(OFS_ENABLE, 32'h0000_005a);
        wr(OFS_ERR_EN, 32'hff);
        rdc(OFS_ERR_EN, 32'h0000_00ff);
        for (int k = 7; k >= 1; k--) begin
            src(k, k, 1'h1, 1'h1);
            src(k, k, 1'h0, 1'h1);
        end
        wr(OFS_ERR_EN, 32'h0);
        fire(ev_of(1));
        rdc(OFS_ERR_FLAGS, 32'h0000_0001);
        rdc(OFS_FLAGS, 32'h0);
        chk1(irq, 1'h0);
        wr(OFS_ERR_FLAGS, 32'hff);
        rdc(OFS_ERR_FLAGS, 32'h0);
        src(1, 1, 1'h1, 1'h0);
        src(0, 0, 1'h1, 1'h1);
        src(0, 0, 1'h0, 1'h1);
        src(8, 0, 1'h1, 1'h0);
        wr(OFS_CTRL, 32'h1);
        rdc(OFS_CTRL, 32'h0000_0001);
        src(8, 0, 1'h1, 1'h1);
        src(8, 0, 1'h0, 1'h1);
        src(0, 0, 1'h1, 1'h0);
        wr(OFS_ENABLE, 32'hff);
        fire(ev_of(7));
        chk1(irq, 1'h1);
        rst_i <= 1'h1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'h0;
        @(posedge clk_i);
        chk1(irq, 1'h0);
        rdc(OFS_ENABLE, 32'h0);
        rdc(OFS_FLAGS, 32'h0);
        rdc(OFS_CTRL, 32'h0);
        close_out();
    end
endmodule // tb
